// File: src/ets_consts.vh
// exposure trigger sequencer: register map, field layout, reset values, timing counts
// assumes a 50 MHz sys_clk and word-indexed Avalon-MM addressing
`ifndef ETS_CONSTS_VH
`define ETS_CONSTS_VH

// word indices; byte address is four times the index
`define ETS_REG_CTRL      3'h0
`define ETS_REG_EXPOSE    3'h1
`define ETS_REG_SOFTTRIG  3'h2
`define ETS_REG_STATUS    3'h3
`define ETS_REG_FRAMELEN  3'h4

// control fields
`define ETS_CTRL_STREAM   0
`define ETS_CTRL_MODE_LO  1
`define ETS_CTRL_MODE_HI  3
`define ETS_CTRL_SRC_LO   4
`define ETS_CTRL_SRC_HI   5
`define ETS_CTRL_RATE40   6
`define ETS_CTRL_RISING   7

// operating modes
`define ETS_MODE_OVERLAP  3'h0
`define ETS_MODE_EXTENDED 3'h1
`define ETS_MODE_NONOVL   3'h2
`define ETS_MODE_SINGLE   3'h3
`define ETS_MODE_BULB     3'h4

// trigger sources
`define ETS_SRC_EXT       2'h0
`define ETS_SRC_LINE      2'h1
`define ETS_SRC_SOFT      2'h2

// reset values
`define ETS_CTRL_RST      8'h06
`define ETS_EXPOSE_RST    24'h000001
`define ETS_FRAMELEN_RST  24'h15AA40
`define ETS_STREAM_RST    1'b0

// timing: exposure step in ns and its cycle count at the sys_clk period
`define ETS_CLK_NS        20
`define ETS_STEP20_NS     77000
`define ETS_STEP40_NS     41000
`define ETS_STEP20_CYC    (`ETS_STEP20_NS / `ETS_CLK_NS)
`define ETS_STEP40_CYC    (`ETS_STEP40_NS / `ETS_CLK_NS)
// last divider count of one step, sized for the 12-bit step counter
`define ETS_STEP20_LAST   12'hF09
`define ETS_STEP40_LAST   12'h801

// pixel-rate enable: phase accumulator modulo 5 at 50 MHz
`define ETS_RATE_MOD      4'h5
`define ETS_RATE_INC20    4'h2
`define ETS_RATE_INC40    4'h4
// modulus at accumulator width; wraps correctly in 3-bit arithmetic
`define ETS_RATE_WRAP     3'h5

`endif

// File: src/ets_sequencer.v
// exposure trigger sequencer top: Avalon-MM registers, mode state machine, readout pacing
// assumes sensor pins are asynchronous; sys_clk is 50 MHz
//
// What this block does
// - no exposure before a selected-source trigger
// - continuous modes stream until host disables
// - single mode: one exposure per leading edge
// - bulb exposes from leading to trailing edge
// - bulb readout starts at trailing edge
// - trigger from pin, line or command
// - 20 or 40 MHz rate, 12-bit samples
// - every mode works at either rate
// - single mode ignores triggers until readout ends
// - exposure steps 77 us or 41 us
`timescale 1ns/1ps
`include "ets_consts.vh"

module ets_sequencer (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // avalon-mm slave
   input  wire [2:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   // trigger pins
   input  wire        extTrigger_n,
   input  wire        lineTrigger_n,
   // sensor
   input  wire [11:0] sensorData,
   output reg         sensorExpose,
   output reg         sensorReadout,
   // pixel stream
   output reg         pixelStrobe,
   output reg  [11:0] pixelData,
   output reg         pixelValid,
   output reg         frameStart
);

   localparam ST_IDLE    = 3'h0;
   localparam ST_EXPOSE  = 3'h1;
   localparam ST_READOUT = 3'h2;
   localparam ST_BULB    = 3'h3;
   localparam ST_WAITEXP = 3'h4;

   localparam [11:0] STEP20_LAST = `ETS_STEP20_LAST;
   localparam [11:0] STEP40_LAST = `ETS_STEP40_LAST;

   // zero counts are raised to one so a frame always has a length
   function [23:0] atLeastOne;
      input [23:0] value;
      begin
         atLeastOne = (value == 24'h0) ? 24'h1 : value;
      end
   endfunction

   // registers
   reg        streamEn;
   reg [2:0]  mode;
   reg [1:0]  srcSel;
   reg        rate40;
   reg        leadRising;
   reg [23:0] expSteps;
   reg [23:0] frameLen;
   reg        softLevel;
   reg [15:0] frameCount;

   // sequencer state
   reg [2:0]  state;
   reg        expRun;
   reg [23:0] expLeft;
   reg        readRun;
   reg [23:0] readLeft;
   reg [11:0] stepCnt;
   reg [2:0]  rateAcc;
   reg        pixTick;
   reg [11:0] dataMeta;
   reg [11:0] dataSync;

   reg [2:0]  next_state;
   reg        next_expRun;
   reg [23:0] next_expLeft;
   reg        next_readRun;
   reg [23:0] next_readLeft;
   reg        next_frameStart;
   reg [3:0]  next_rateSum;

   wire       trigLevel;
   wire       trigLead;
   wire       trigTrail;
   wire [11:0] stepLast;
   wire       stepTick;
   wire       expDone;
   wire       readDone;
   wire       continuous;
   wire       overlap;
   wire       armOk;

   ets_trig_sync uTrig (
      .sys_clk       (sys_clk),
      .rst_n         (rst_n),
      .extTrigger_n  (extTrigger_n),
      .lineTrigger_n (lineTrigger_n),
      .softLevel     (softLevel),
      .srcSel        (srcSel),
      .leadRising    (leadRising),
      .trigLevel     (trigLevel),
      .trigLead      (trigLead),
      .trigTrail     (trigTrail)
   );

   assign stepLast   = rate40 ? STEP40_LAST : STEP20_LAST;
   assign stepTick   = expRun && (stepCnt == stepLast);
   assign expDone    = stepTick && (expLeft == 24'h1);
   assign readDone   = readRun && pixTick && (readLeft == 24'h1);
   assign continuous = (mode == `ETS_MODE_OVERLAP) || (mode == `ETS_MODE_EXTENDED) ||
                       (mode == `ETS_MODE_NONOVL);
   assign overlap    = (mode == `ETS_MODE_OVERLAP) || (mode == `ETS_MODE_EXTENDED);
   // continuous modes arm only while streaming is enabled
   assign armOk      = continuous ? streamEn :
                       ((mode == `ETS_MODE_SINGLE) || (mode == `ETS_MODE_BULB));

   // pixel-rate enable: 2/5 or 4/5 of sys_clk gives 20 or 40 MHz
   always @* begin
      next_rateSum = {1'b0, rateAcc} + (rate40 ? `ETS_RATE_INC40 : `ETS_RATE_INC20);
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rateAcc <= 3'h0;
         pixTick <= 1'b0;
      end else if (next_rateSum >= `ETS_RATE_MOD) begin
         rateAcc <= next_rateSum[2:0] - `ETS_RATE_WRAP;
         pixTick <= 1'b1;
      end else begin
         rateAcc <= next_rateSum[2:0];
         pixTick <= 1'b0;
      end
   end

   // exposure step divider, idle at zero between exposures
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         stepCnt <= 12'h0;
      else if (!expRun || stepTick)
         stepCnt <= 12'h0;
      else
         stepCnt <= stepCnt + 12'h1;
   end

   always @* begin
      next_state      = state;
      next_expRun     = expRun;
      next_expLeft    = expLeft;
      next_readRun    = readRun;
      next_readLeft   = readLeft;
      next_frameStart = 1'b0;
      if (expDone)
         next_expRun = 1'b0;
      else if (stepTick)
         next_expLeft = expLeft - 24'h1;
      if (readDone)
         next_readRun = 1'b0;
      else if (readRun && pixTick)
         next_readLeft = readLeft - 24'h1;
      case (state)
         ST_IDLE: begin
            // triggers outside idle fall through unused
            if (trigLead && armOk) begin
               if (mode == `ETS_MODE_BULB) begin
                  next_state = ST_BULB;
               end else begin
                  next_state   = ST_EXPOSE;
                  next_expRun  = 1'b1;
                  next_expLeft = atLeastOne(expSteps);
               end
            end
         end
         ST_EXPOSE: begin
            if (expDone) begin
               next_state      = ST_READOUT;
               next_readRun    = 1'b1;
               next_readLeft   = atLeastOne(frameLen);
               next_frameStart = 1'b1;
               if (overlap && streamEn) begin
                  next_expRun  = 1'b1;
                  next_expLeft = atLeastOne(expSteps);
               end
            end
         end
         ST_BULB: begin
            if (trigTrail) begin
               next_state      = ST_READOUT;
               next_readRun    = 1'b1;
               next_readLeft   = atLeastOne(frameLen);
               next_frameStart = 1'b1;
            end
         end
         ST_READOUT: begin
            if (readDone) begin
               if (continuous && streamEn) begin
                  if (!overlap) begin
                     next_state   = ST_EXPOSE;
                     next_expRun  = 1'b1;
                     next_expLeft = atLeastOne(expSteps);
                  end else if (expRun && !expDone) begin
                     next_state = ST_WAITEXP;
                  end else begin
                     next_readRun    = 1'b1;
                     next_readLeft   = atLeastOne(frameLen);
                     next_frameStart = 1'b1;
                     next_expRun     = 1'b1;
                     next_expLeft    = atLeastOne(expSteps);
                  end
               end else begin
                  next_state  = ST_IDLE;
                  next_expRun = 1'b0;
               end
            end
         end
         ST_WAITEXP: begin
            if (!streamEn) begin
               next_state  = ST_IDLE;
               next_expRun = 1'b0;
            end else if (expDone) begin
               next_state      = ST_READOUT;
               next_readRun    = 1'b1;
               next_readLeft   = atLeastOne(frameLen);
               next_frameStart = 1'b1;
               next_expRun     = 1'b1;
               next_expLeft    = atLeastOne(expSteps);
            end
         end
         default: begin
            next_state   = ST_IDLE;
            next_expRun  = 1'b0;
            next_readRun = 1'b0;
         end
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state         <= ST_IDLE;
         expRun        <= 1'b0;
         expLeft       <= 24'h0;
         readRun       <= 1'b0;
         readLeft      <= 24'h0;
         sensorExpose  <= 1'b0;
         sensorReadout <= 1'b0;
         frameStart    <= 1'b0;
         frameCount    <= 16'h0;
      end else begin
         state         <= next_state;
         expRun        <= next_expRun;
         expLeft       <= next_expLeft;
         readRun       <= next_readRun;
         readLeft      <= next_readLeft;
         sensorExpose  <= next_expRun || (next_state == ST_BULB);
         sensorReadout <= next_readRun;
         frameStart    <= next_frameStart;
         if (next_frameStart)
            frameCount <= frameCount + 16'h1;
      end
   end

   // sensor samples cross from the converter pins
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dataMeta    <= 12'h000;
         dataSync    <= 12'h000;
         pixelData   <= 12'h000;
         pixelStrobe <= 1'b0;
         pixelValid  <= 1'b0;
      end else begin
         dataMeta    <= sensorData;
         dataSync    <= dataMeta;
         pixelStrobe <= pixTick;
         pixelValid  <= readRun && pixTick;
         if (readRun && pixTick)
            pixelData <= dataSync;
      end
   end

   // avalon slave: waitrequest drops one cycle after the request, access completes then
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         streamEn        <= `ETS_STREAM_RST;
         mode            <= `ETS_MODE_SINGLE;
         srcSel          <= `ETS_SRC_EXT;
         rate40          <= 1'b0;
         leadRising      <= 1'b0;
         expSteps        <= `ETS_EXPOSE_RST;
         frameLen        <= `ETS_FRAMELEN_RST;
         softLevel       <= 1'b0;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         // writes leave the last read word standing
         if (!avs_read)
            avs_readdata <= avs_readdata;
         else if (avs_address == `ETS_REG_CTRL)
            avs_readdata <= {24'h0, leadRising, rate40, srcSel, mode, streamEn};
         else if (avs_address == `ETS_REG_EXPOSE)
            avs_readdata <= {8'h00, expSteps};
         else if (avs_address == `ETS_REG_SOFTTRIG)
            avs_readdata <= {31'h0, softLevel};
         else if (avs_address == `ETS_REG_STATUS)
            avs_readdata <= {frameCount, 9'h0, trigLevel, readRun, expRun, 1'b0, state};
         else if (avs_address == `ETS_REG_FRAMELEN)
            avs_readdata <= {8'h00, frameLen};
         else
            avs_readdata <= 32'h00000000;
      end else begin
         avs_waitrequest <= 1'b1;
         if (avs_write && !avs_waitrequest) begin
            if (avs_address == `ETS_REG_CTRL) begin
               streamEn   <= avs_writedata[`ETS_CTRL_STREAM];
               mode       <= avs_writedata[`ETS_CTRL_MODE_HI:`ETS_CTRL_MODE_LO];
               srcSel     <= avs_writedata[`ETS_CTRL_SRC_HI:`ETS_CTRL_SRC_LO];
               rate40     <= avs_writedata[`ETS_CTRL_RATE40];
               leadRising <= avs_writedata[`ETS_CTRL_RISING];
            end else if (avs_address == `ETS_REG_EXPOSE) begin
               expSteps <= avs_writedata[23:0];
            end else if (avs_address == `ETS_REG_SOFTTRIG) begin
               softLevel <= avs_writedata[0];
            end else if (avs_address == `ETS_REG_FRAMELEN) begin
               frameLen <= avs_writedata[23:0];
            end
         end
      end
   end

endmodule // ets_sequencer

// File: src/ets_trig_sync.v
// trigger conditioner: synchronises the pin triggers, selects one source, finds edges
// assumes pins are asynchronous to sys_clk; soft trigger level is already on sys_clk
`timescale 1ns/1ps
`include "ets_consts.vh"

module ets_trig_sync (
   // clock and reset
   input  wire       sys_clk,
   input  wire       rst_n,
   // raw triggers
   input  wire       extTrigger_n,
   input  wire       lineTrigger_n,
   input  wire       softLevel,
   // selection
   input  wire [1:0] srcSel,
   input  wire       leadRising,
   // conditioned trigger
   output reg        trigLevel,
   output reg        trigLead,
   output reg        trigTrail
);

   reg  [1:0] pinMeta;
   reg  [1:0] pinSync;
   reg  [2:0] actPrev;
   reg        selAct;
   reg        selGoAct;
   reg        selGoIdle;
   wire [2:0] actNow;
   wire [2:0] goAct;
   wire [2:0] goIdle;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta <= 2'h3;
         pinSync <= 2'h3;
      end else begin
         pinMeta <= {lineTrigger_n, extTrigger_n};
         pinSync <= pinMeta;
      end
   end

   // edges found per source ahead of the mux, so a source or polarity
   // change never looks like a trigger edge
   assign actNow = {softLevel, ~pinSync[1], ~pinSync[0]};
   assign goAct  = actNow & ~actPrev;
   assign goIdle = ~actNow & actPrev;

   always @* begin
      selAct    = 1'b0;
      selGoAct  = 1'b0;
      selGoIdle = 1'b0;
      if (srcSel == `ETS_SRC_EXT) begin
         selAct    = actNow[0];
         selGoAct  = goAct[0];
         selGoIdle = goIdle[0];
      end else if (srcSel == `ETS_SRC_LINE) begin
         selAct    = actNow[1];
         selGoAct  = goAct[1];
         selGoIdle = goIdle[1];
      end else if (srcSel == `ETS_SRC_SOFT) begin
         selAct    = actNow[2];
         selGoAct  = goAct[2];
         selGoIdle = goIdle[2];
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         actPrev   <= 3'h0;
         trigLevel <= 1'b0;
         trigLead  <= 1'b0;
         trigTrail <= 1'b0;
      end else begin
         actPrev   <= actNow;
         // default leading edge is high-to-low on the pins, low-to-high on softLevel
         trigLevel <= leadRising ? ~selAct : selAct;
         trigLead  <= leadRising ? selGoIdle : selGoAct;
         trigTrail <= leadRising ? selGoAct : selGoIdle;
      end
   end

endmodule // ets_trig_sync

// File: verif/ets_seq_asserts.sv
// checker on the sequencer top ports: bus handshake, trigger gating, pixel pacing
// assumes it is bound to every ets_sequencer instance
`timescale 1ns/1ps
module ets_seq_asserts (
   // clock and reset
   input wire        sys_clk,
   input wire        rst_n,
   // bus
   input wire [2:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   // pins and outputs
   input wire        extTrigger_n,
   input wire        lineTrigger_n,
   input wire        sensorExpose,
   input wire        pixelStrobe,
   input wire        frameStart
);
   reg sawTrig;
   // a write may be a soft trigger, so any write counts
   always @(posedge sys_clk or negedge rst_n)
      if (!rst_n) sawTrig <= 1'b0;
      else if (!extTrigger_n || !lineTrigger_n || avs_write) sawTrig <= 1'b1;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_no_early_exp: assert property (!sawTrig |-> !sensorExpose)
      else $error("exposure before any trigger");
   a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer one cycle after request");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read) || $past(avs_write))
      else $error("answer without request");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 3'h4
      |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
   a_ctrl_upper: assert property (avs_read && !avs_waitrequest && avs_address == 3'h0
      |-> avs_readdata[31:8] == 24'h0) else $error("control upper bits set");
   a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without read");
   a_start_pulse: assert property (frameStart |=> !frameStart)
      else $error("frame start longer than one cycle");
   a_strobe_rate: assert property (pixelStrobe [*4] |=> !pixelStrobe)
      else $error("pixel strobe above rate");
   c_frame: cover property (frameStart);
   c_expose: cover property ($rose(sensorExpose));
   c_write: cover property (avs_write && !avs_waitrequest);
endmodule // ets_seq_asserts

bind ets_sequencer ets_seq_asserts chk (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest, .extTrigger_n, .lineTrigger_n, .sensorExpose,
   .pixelStrobe, .frameStart);

// File: verif/ets_sequencer_tb.sv
// self-checking bench: registers, trigger sources, modes and rates
// assumes the checker binds itself and the model drives the pins
`timescale 1ns/1ps
`include "ets_consts.vh"
module ets_sequencer_tb;
   reg          sys_clk, rst_n, avs_read, avs_write;
   reg  [2:0]   avs_address;
   reg  [31:0]  avs_writedata;
   wire [31:0]  avs_readdata;
   wire         avs_waitrequest, extTrigger_n, lineTrigger_n, sensorExpose, sensorReadout;
   wire         pixelStrobe, pixelValid, frameStart;
   wire [11:0]  sensorData, pixelData;
   int          error_cnt = 0, compares = 0, frames = 0, pixCnt = 0, expLen = 0;
   int          cyc = 0, tFall = 0, tStart = 0, strobes = 0;
   logic        expPrev = 1'b0;
   logic [35:0] sdHist;
   logic [31:0] expQ[$], mskQ[$];

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   ets_sequencer dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_readdata, .avs_waitrequest, .extTrigger_n, .lineTrigger_n, .sensorData,
      .sensorExpose, .sensorReadout, .pixelStrobe, .pixelData, .pixelValid, .frameStart);
   ets_trig_model model (.sys_clk, .extTrigger_n, .lineTrigger_n, .sensorData);

   task final_report;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s exp %h got %h", what, e, g);
      end
   endtask
   task tmo(input string what);
      chk(what, 1, 0);
      final_report;
   endtask
   // monitor: read data against the oldest note, exposure and frame timing
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      expPrev <= sensorExpose;
      if (sensorExpose) expLen <= expPrev ? expLen + 1 : 1;
      if (expPrev && !sensorExpose) tFall <= cyc;
      if (frameStart) tStart <= cyc;
      if (frameStart) frames <= frames + 1;
      pixCnt <= (frameStart ? 0 : pixCnt) + int'(pixelValid);
      strobes <= strobes + int'(pixelStrobe);
      sdHist <= {sdHist[23:0], sensorData};
      // a sample passes two sync flops and the capture flop
      if (pixelValid !== 1'b0) chk("pixelData", sdHist[35:24], pixelData);
      if (avs_read && avs_waitrequest === 1'b0) chk("readdata", expQ.pop_front(),
         avs_readdata & mskQ.pop_front());
   end
   task bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
      int n;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) tmo("bus");
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task wr(input logic [2:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd(input logic [2:0] a, input logic [31:0] e, input logic [31:0] m);
      expQ.push_back(e & m);
      mskQ.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask
   task waitf(input int n);
      int k;
      for (k = 0; k < 30000 && (frames < n || sensorReadout !== 1'b0); k++) @(posedge sys_clk);
      if (k >= 30000) tmo("frame");
      repeat (20) @(posedge sys_clk);
   endtask
   task fire(input logic [1:0] s, input int w);
      if (s == `ETS_SRC_SOFT) begin
         wr(`ETS_REG_SOFTTRIG, 32'h1);
         repeat (w) @(posedge sys_clk);
         wr(`ETS_REG_SOFTTRIG, 32'h0);
      end else model.pulse(s == `ETS_SRC_LINE, w);
   endtask

   initial begin
      int f, n, w, s, t;
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 3'h0;
      avs_writedata = 32'h0;
      void'($urandom(5238));
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`ETS_REG_CTRL, `ETS_CTRL_RST, 32'hFFFFFFFF);
      rd(`ETS_REG_EXPOSE, `ETS_EXPOSE_RST, 32'hFFFFFFFF);
      rd(`ETS_REG_FRAMELEN, `ETS_FRAMELEN_RST, 32'hFFFFFFFF);
      rd(`ETS_REG_STATUS, 32'h0, 32'hFFFF0007);
      wr(3'h5, 32'hFFFFFFFF);
      rd(3'h5, 32'h0, 32'hFFFFFFFF);
      wr(`ETS_REG_FRAMELEN, 32'h4);
      // line pulse while the ext pin is selected: nothing may start
      model.pulse(1'b1, 20);
      repeat (100) @(posedge sys_clk);
      chk("frames", 0, frames);
      for (s = 0; s < 3; s++) begin
         n = 1 + $urandom % 2;
         w = 8 + $urandom % 32;
         wr(`ETS_REG_EXPOSE, n);
         wr(`ETS_REG_CTRL, {1'b0, s[0], s[1:0], `ETS_MODE_SINGLE, 1'b0});
         f = frames;
         fire(s[1:0], w);
         repeat (w) @(posedge sys_clk);
         fire(s[1:0], w);
         waitf(f + 1);
         chk("expLen", n * (s[0] ? `ETS_STEP40_CYC : `ETS_STEP20_CYC), expLen);
         chk("pixels", 4, pixCnt);
         repeat (200) @(posedge sys_clk);
         chk("rearm", 0, sensorExpose);
         t = strobes;
         repeat (100) @(posedge sys_clk);
         chk("strobeRate", s[0] ? 80 : 40, strobes - t);
         rd(`ETS_REG_STATUS, (f + 1) << 16, 32'hFFFF0007);
      end
      // rising leading edge: no event from the polarity write, start after release
      wr(`ETS_REG_CTRL, {2'h3, `ETS_SRC_EXT, `ETS_MODE_SINGLE, 1'b0});
      f = frames;
      repeat (20) @(posedge sys_clk);
      chk("polarityEdge", 0, sensorExpose);
      fire(`ETS_SRC_EXT, w);
      chk("leadRise", 0, sensorExpose);
      waitf(f + 1);
      chk("riseFrames", f + 1, frames);
      w = 50 + $urandom % 200;
      wr(`ETS_REG_CTRL, {2'h1, `ETS_SRC_EXT, `ETS_MODE_BULB, 1'b0});
      f = frames;
      fire(`ETS_SRC_EXT, w);
      waitf(f + 1);
      chk("bulbLen", w, expLen);
      chk("readLag", 1, tStart - tFall <= 1 && tStart >= tFall);
      for (s = 0; s < 3; s++) begin
         wr(`ETS_REG_EXPOSE, 32'h1);
         wr(`ETS_REG_CTRL, {1'b0, s[0], `ETS_SRC_EXT, s[2:0], 1'b1});
         f = frames;
         fire(`ETS_SRC_EXT, 16);
         waitf(f + 3);
         wr(`ETS_REG_CTRL, {1'b0, s[0], `ETS_SRC_EXT, s[2:0], 1'b0});
         n = frames;
         repeat (6000) @(posedge sys_clk);
         chk("stopped", 1, frames <= n + 1);
         rd(`ETS_REG_STATUS, 32'h0, 32'h7);
      end
      final_report;
   end
endmodule // ets_sequencer_tb

// File: verif/ets_trig_model.sv
// far-side model: trigger pins and converter samples
// assumes the bench calls pulse() just after a clock edge
`timescale 1ns/1ps
module ets_trig_model (
   // clock
   input wire        sys_clk,
   // pins and samples
   output reg        extTrigger_n,
   output reg        lineTrigger_n,
   output reg [11:0] sensorData
);
   initial begin
      extTrigger_n = 1'b1;
      lineTrigger_n = 1'b1;
      sensorData = 12'h000;
   end
   // samples change every cycle so a stale capture shows
   always @(posedge sys_clk) sensorData <= 12'($urandom);
   task pulse(input logic line, input int w);
      if (line) lineTrigger_n <= 1'b0;
      else extTrigger_n <= 1'b0;
      repeat (w) @(posedge sys_clk);
      lineTrigger_n <= 1'b1;
      extTrigger_n <= 1'b1;
   endtask
endmodule // ets_trig_model
